// [src/rimb_pkg.sv]
package rimb_pkg;
    // register offsets on the internal register port
    localparam logic [7:0] TOP_EVENT_MASK_TWO_OFS = 8'h21;
    localparam logic [7:0] BUCK_EVENT_MASK_OFS = 8'h22;
    localparam logic [7:0] LINEAR_REG_EVENT_MASK_OFS = 8'h23;
    // reset values
    localparam logic [7:0] TOP_EVENT_MASK_TWO_RST = 8'h01;
    localparam logic [7:0] RAIL_EVENT_MASK_RST = 8'hDD;
    // writable bits of each register
    localparam logic [7:0] TOP_WRITABLE = 8'hFE;
    localparam logic [7:0] RAIL_WRITABLE = 8'hDD;
    // register-reset gate position
    localparam int REG_RESET_GATE_BIT = 0;
    // per-rail field positions inside a nibble; second rail of a register sits 4 higher
    localparam int RAIL_NIBBLE_STRIDE = 4;
    localparam int PWROK_FALL_GATE_POS = 3;
    localparam int PWROK_RISE_GATE_POS = 2;
    localparam int OVERCURRENT_GATE_POS = 0;
    // rail order: conv0, conv1, lin0, lin1
    localparam int RAIL_COUNT = 4;
    localparam int RAILS_PER_REG = 2;

    typedef struct packed {
        logic pwrokRaw;        // 1 = output invalid
        logic overcurrentRaw;  // 1 = current limit active
    } rimb_rail_stat_t;

    typedef struct packed {
        logic pwrokFlag;       // set pulse for the power-good flag
        logic overcurrentFlag; // set pulse for the current-limit flag
    } rimb_rail_evt_t;
endpackage

// [src/rimb_mask_bank.sv]
`timescale 1ns/100ps
`default_nettype none
// How it works
// RQ1: top mask bit 0 suppresses register-reset flag when 1, defaults 1.
// RQ2: host writes to that bit are ignored; it reloads from OTP on reset.
// RQ3: mask 0 lets an interrupt be raised, mask 1 blocks it.
// RQ4: buck bit 7 gates conv1 power-good valid-to-invalid event, default 1.
// RQ5: buck bit 6 gates conv1 power-good invalid-to-valid event, default 1.
// RQ6: buck bit 4 gates conv1 current-limit event, default 1.
// RQ7: buck bit 3 gates conv0 power-good transition to invalid.
// RQ8: buck bit 2 gates conv0 power-good transition to valid.
// RQ9: buck bit 0 gates conv0 current-limit event.
// RQ10: masks gate only flag setting; raw status stays live.
// RQ11: buck bits 5,1 read 0; top bits 7:1 writable, default 0.
// RQ12: linear mask at 0x23 uses the same layout for lin1 and lin0.
// RQ13: linear power-good gates act per direction, default 1, raw untouched.
// RQ14: masked events never set flags, not even after later unmasking.
module rimb_mask_bank (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    // register port
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    input wire logic regRdEn,
    output logic [7:0] regRdData,
    // OTP reload of the register-reset gate
    input wire logic otpResetMask,
    input wire logic regResetEvent,
    output logic regResetFlagSet,
    // rail status in, rail raw status and flag set pulses out
    input wire rimb_pkg::rimb_rail_stat_t [rimb_pkg::RAIL_COUNT-1:0] railStat,
    output rimb_pkg::rimb_rail_stat_t [rimb_pkg::RAIL_COUNT-1:0] railRaw,
    output rimb_pkg::rimb_rail_evt_t [rimb_pkg::RAIL_COUNT-1:0] railEvt
);
    import rimb_pkg::*;

    // mask registers and the pending OTP reload
    logic [7:0] topMask_reg, topMask_next;
    logic [7:0] buckMask_reg, buckMask_next;
    logic [7:0] linMask_reg, linMask_next;
    logic reloadPending_reg, reloadPending_next;
    // read data, register-reset flag pulse, rail sampling primed
    logic [7:0] rdData_reg, rdData_next;
    logic regResetFlag_reg, regResetFlag_next;
    logic primed_reg, primed_next;
    // per-rail outputs gathered from the generate loop
    wire rimb_rail_stat_t [RAIL_COUNT-1:0] rawBus;
    wire rimb_rail_evt_t [RAIL_COUNT-1:0] evtBus;

    // mask registers: next values
    always_comb begin
        topMask_next = topMask_reg;
        buckMask_next = buckMask_reg;
        linMask_next = linMask_reg;
        reloadPending_next = reloadPending_reg;
        if (regWrEn) begin
            case (regAddr)
                TOP_EVENT_MASK_TWO_OFS: begin
                    // gate bit kept, a write there would be undone by the next reload
                    topMask_next = (regWrData & TOP_WRITABLE) |
                        (topMask_reg & ~TOP_WRITABLE); // RQ2 RQ11
                end
                BUCK_EVENT_MASK_OFS: begin
                    buckMask_next = regWrData & RAIL_WRITABLE; // RQ11
                end
                LINEAR_REG_EVENT_MASK_OFS: begin
                    linMask_next = regWrData & RAIL_WRITABLE; // RQ12
                end
                default: begin
                    // unmapped writes are dropped
                end
            endcase
        end
        // OTP is sampled after reset release, never inside the async reset
        if (reloadPending_reg) begin
            topMask_next[REG_RESET_GATE_BIT] = otpResetMask; // RQ2
            reloadPending_next = 1'b0;
        end
        if (regResetEvent) begin
            reloadPending_next = 1'b1; // RQ2
        end
    end

    // mask registers: state
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            topMask_reg <= TOP_EVENT_MASK_TWO_RST; // RQ1 RQ11
            buckMask_reg <= RAIL_EVENT_MASK_RST;
            linMask_reg <= RAIL_EVENT_MASK_RST; // RQ13
            reloadPending_reg <= 1'b1;
        end else if (clkEn) begin
            topMask_reg <= topMask_next;
            buckMask_reg <= buckMask_next;
            linMask_reg <= linMask_next;
            reloadPending_reg <= reloadPending_next;
        end
    end

    // reserved bits are zero in storage and masked again on read
    always_comb begin
        rdData_next = rdData_reg;
        if (regRdEn) begin
            case (regAddr)
                TOP_EVENT_MASK_TWO_OFS: begin
                    rdData_next = topMask_reg;
                end
                BUCK_EVENT_MASK_OFS: begin
                    rdData_next = buckMask_reg & RAIL_WRITABLE; // RQ11
                end
                LINEAR_REG_EVENT_MASK_OFS: begin
                    rdData_next = linMask_reg & RAIL_WRITABLE; // RQ11
                end
                default: begin
                    // unmapped reads return zero
                    rdData_next = 8'h00;
                end
            endcase
        end
    end

    // read data stands until the next read
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdData_reg <= 8'h00;
        end else if (clkEn) begin
            rdData_reg <= rdData_next;
        end
    end

    // gate read in the event cycle only, so a later unmask raises nothing
    always_comb begin
        regResetFlag_next = regResetEvent &
            ~topMask_reg[REG_RESET_GATE_BIT]; // RQ1 RQ3 RQ14
    end

    // pulse lasts one cycle; clkEn low stretches it
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            regResetFlag_reg <= 1'b0;
        end else if (clkEn) begin
            regResetFlag_reg <= regResetFlag_next;
        end
    end

    // first enabled edge after reset only loads history, so no false edges
    always_comb begin
        primed_next = 1'b1;
    end

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            primed_reg <= 1'b0;
        end else if (clkEn) begin
            primed_reg <= primed_next;
        end
    end

    // one detector per rail; flags themselves live outside, only set pulses leave
    // limitation: a status change shorter than one clock is not seen
    for (genvar r = 0; r < RAIL_COUNT; r++) begin : g_rail
        localparam int BASE = (r % RAILS_PER_REG) * RAIL_NIBBLE_STRIDE;
        rimb_rail_stat_t prev_reg, prev_next;
        rimb_rail_stat_t raw_reg, raw_next;
        rimb_rail_evt_t evt_reg, evt_next;
        logic [7:0] maskByte;
        logic fallGate;
        logic riseGate;
        logic ocGate;
        logic goesInvalid;
        logic goesValid;
        logic ocStarts;

        // conv rails take the buck register, lin rails the linear one
        assign maskByte = (r < RAILS_PER_REG) ? buckMask_reg : linMask_reg; // RQ12 RQ13
        assign fallGate = maskByte[BASE + PWROK_FALL_GATE_POS]; // RQ4 RQ7
        assign riseGate = maskByte[BASE + PWROK_RISE_GATE_POS]; // RQ5 RQ8
        assign ocGate = maskByte[BASE + OVERCURRENT_GATE_POS]; // RQ6 RQ9

        // pwrokRaw 0 to 1 is the fall to invalid, 1 to 0 the rise back to valid
        assign goesInvalid = railStat[r].pwrokRaw & ~prev_reg.pwrokRaw;
        assign goesValid = ~railStat[r].pwrokRaw & prev_reg.pwrokRaw;
        assign ocStarts = railStat[r].overcurrentRaw & ~prev_reg.overcurrentRaw;

        always_comb begin
            prev_next = railStat[r];
            // raw status is never masked
            raw_next = railStat[r]; // RQ10
            evt_next.pwrokFlag = primed_reg &
                ((goesInvalid & ~fallGate) | (goesValid & ~riseGate)); // RQ3 RQ14
            evt_next.overcurrentFlag = primed_reg & ocStarts & ~ocGate; // RQ3 RQ14
        end

        // history resets to all valid, no current limit
        always_ff @(posedge clk or posedge sys_rst) begin
            if (sys_rst) begin
                prev_reg <= '0;
                raw_reg <= '0;
                evt_reg <= '0;
            end else if (clkEn) begin
                prev_reg <= prev_next;
                raw_reg <= raw_next;
                evt_reg <= evt_next;
            end
        end

        assign rawBus[r] = raw_reg;
        assign evtBus[r] = evt_reg;
    end

    assign regRdData = rdData_reg;
    assign regResetFlagSet = regResetFlag_reg;
    assign railRaw = rawBus;
    assign railEvt = evtBus;
endmodule
`default_nettype wire

// [tb/rimb_host_model.sv]
`timescale 1ns/100ps
`default_nettype none
module rimb_host_model (
    // register port
    input wire logic clk,
    output logic [7:0] regAddr,
    output logic regWrEn,
    output logic [7:0] regWrData,
    output logic regRdEn
);
    initial {regAddr, regWrEn, regWrData, regRdEn} = '0;
    // one-cycle strobe; released data inverts so stale values never match
    task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        {regAddr, regWrEn, regWrData, regRdEn} = {a, w, d, !w};
        @(negedge clk);
        {regWrEn, regRdEn, regWrData} = {2'b00, ~d};
    endtask
endmodule
`default_nettype wire

// [tb/rimb_mask_bank_sva.sv]
`timescale 1ns/100ps
`default_nettype none
module rimb_mask_bank_sva (
    // watched ports
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic clkEn,
    input wire logic [7:0] regAddr,
    input wire logic regRdEn,
    input wire logic [7:0] regRdData,
    input wire logic regResetEvent,
    input wire logic regResetFlagSet,
    input wire rimb_pkg::rimb_rail_stat_t [3:0] railStat,
    input wire rimb_pkg::rimb_rail_stat_t [3:0] railRaw,
    input wire rimb_pkg::rimb_rail_evt_t [3:0] railEvt
);
    import rimb_pkg::*;
    default clocking @(posedge clk); endclocking
    default disable iff (sys_rst);
    sequence rdOf(a); regRdEn && regAddr == a; endsequence
    a_raw_live: assert property (clkEn |=> railRaw == $past(railStat))
        else $error("raw lag");
    a_resv_zero: assert property (clkEn ##0 (rdOf(8'h22) or rdOf(8'h23))
        |=> (regRdData & 8'h22) == 0) else $error("reserved set");
    a_unmapped_zero: assert property (clkEn && regRdEn &&
        (regAddr < 8'h21 || regAddr > 8'h23) |=> regRdData == 8'h00) else $error("unmapped data");
    a_rd_hold: assert property (!regRdEn |=> $stable(regRdData)) else $error("read moved");
    a_flag_cause: assert property (regResetFlagSet |-> $past(regResetEvent)) else $error("flag");
    a_flag_single: assert property (regResetFlagSet |=> !regResetFlagSet) else $error("long");
    for (genvar i = 0; i < 4; i++) begin : g_rail
        a_pwrok_cause: assert property (railEvt[i].pwrokFlag |->
            $past(railStat[i].pwrokRaw, 2) != $past(railStat[i].pwrokRaw)) else $error("pg");
        a_oc_cause: assert property (railEvt[i].overcurrentFlag |->
            $past(railStat[i].overcurrentRaw) && !$past(railStat[i].overcurrentRaw, 2))
            else $error("oc");
    end
endmodule
bind rimb_mask_bank rimb_mask_bank_sva rimb_mask_bank_sva_inst (.clk(clk), .sys_rst(sys_rst),
    .clkEn(clkEn),
    .regAddr(regAddr), .regRdEn(regRdEn), .regRdData(regRdData), .regResetEvent(regResetEvent),
    .regResetFlagSet(regResetFlagSet), .railStat(railStat), .railRaw(railRaw), .railEvt(railEvt));
`default_nettype wire

// [tb/rimb_mask_bank_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module rimb_mask_bank_bench;
    import rimb_pkg::*;
    logic clk = 0, sys_rst = 1, otpResetMask = 1, regResetEvent = 0, clkEn = 1;
    logic regWrEn, regRdEn, flg, top0 = 1;
    logic [7:0] regAddr, regWrData, regRdData, m22, m23, v, ev, cur = '0, prv = '0;
    rimb_rail_stat_t [RAIL_COUNT-1:0] railStat = '0, railRaw;
    rimb_rail_evt_t [RAIL_COUNT-1:0] railEvt;
    int err_count = 0, n_checks = 0;
    always #50 clk = ~clk;
    rimb_host_model rimb_host_model_inst (.clk(clk), .regAddr(regAddr), .regWrEn(regWrEn),
        .regWrData(regWrData), .regRdEn(regRdEn));
    rimb_mask_bank rimb_mask_bank_inst (.clk(clk), .sys_rst(sys_rst), .clkEn(clkEn),
        .regAddr(regAddr), .regWrEn(regWrEn), .regWrData(regWrData), .regRdEn(regRdEn),
        .regRdData(regRdData), .otpResetMask(otpResetMask), .regResetEvent(regResetEvent),
        .regResetFlagSet(flg), .railStat(railStat), .railRaw(railRaw), .railEvt(railEvt));
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %0t got %h want %h", $time, got, exp);
        end
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] exp);
        rimb_host_model_inst.acc(1'b0, a, 8'h00);
        chk(regRdData, exp);
    endtask
    // pulse seen now comes from the two previous samples
    task automatic step;
        @(negedge clk);
        for (int i = 0; i < 4; i++) begin
            v = (i < 2 ? m22 : m23) >> (i % 2 * 4);
            ev[2*i+1] = prv[2*i+1] != cur[2*i+1] && !v[cur[2*i+1] ? 3 : 2];
            ev[2*i] = !prv[2*i] && cur[2*i] && !v[0];
        end
        chk(railEvt, ev);
        chk(railRaw, cur);
        prv = cur;
        cur = 8'($urandom);
        railStat = cur;
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        void'($urandom(32'h31C7BD49));
        repeat (4) @(negedge clk);
        sys_rst = 0;
        rd(8'h21, 8'h01);
        rd(8'h22, 8'hDD);
        rd(8'h23, 8'hDD);
        rd(8'h30, 8'h00);
        $display("reset values done");
        // a write while clkEn is low must leave no trace
        clkEn = 0;
        rimb_host_model_inst.acc(1'b1, 8'h22, 8'h00);
        clkEn = 1;
        rd(8'h22, 8'hDD);
        $display("clock enable freeze done");
        for (int k = 0; k < 3; k++) begin
            v = 8'($urandom);
            rimb_host_model_inst.acc(1'b1, 8'h21, v);
            rd(8'h21, {v[7:1], top0});
            otpResetMask = k[0];
            @(negedge clk) regResetEvent = 1;
            @(negedge clk) regResetEvent = 0;
            chk({7'h0, flg}, {7'h0, !top0});
            top0 = k[0];
        end
        // second reset in mid-run: gate bit reloads from OTP, upper bits clear
        otpResetMask = 0;
        @(negedge clk) sys_rst = 1;
        repeat (2) @(negedge clk);
        sys_rst = 0;
        rd(8'h21, 8'h00);
        top0 = 0;
        $display("register reset done");
        for (int k = 0; k < 8; k++) begin
            m22 = k ? 8'($urandom) : 8'h00;
            m23 = k ? 8'($urandom) : 8'h00;
            rimb_host_model_inst.acc(1'b1, 8'h22, m22);
            rimb_host_model_inst.acc(1'b1, 8'h23, m23);
            m22 &= RAIL_WRITABLE;
            m23 &= RAIL_WRITABLE;
            rd(8'h22, m22);
            rd(8'h23, m23);
            prv = cur;
            repeat (40) step;
        end
        $display("rail events done");
        give_verdict();
    end
endmodule
`default_nettype wire
